// [hw/xbp_defines.vh]
// How it works
// R1 - ISA interrupts arrive on four muxed pins
// R2 - Line 8 inverted before the controller
// R3 - PCI interrupts arrive on four muxed pins
// R4 - DMA requests arrive on two muxed pins
// R5 - DMA acknowledge sent encoded on three pins
// R6 - Terminal count marks final DMA transfer
// R7 - Speaker is timer 2 AND port 61 bit 1
// R8 - ROM select on decoded memory cycle
// R9 - Clock-chip select on decoded I/O cycle
// R10 - Shared pins carry IDE bits when disabled
// R11 - Keyboard select on decoded I/O cycle
// R12 - Read/write strobe on write to 71H
// R13 - Data strobe on read from 71H
// R14 - Address strobe on write to 70H
// R15 - Board ORs selects with transceiver enable
// R16 - Board qualifies select with bus commands
// R17 - Display channel pins open-drain, register driven
// R18 - Pin 1 clock, pin 0 data
// R19 - Device drives transceiver output enable
// R20 - Muxed inputs sampled in clock phases
`ifndef XBP_DEFINES_VH
`define XBP_DEFINES_VH
`define XBP_PORT_RTC_ADDR 16'h0070
`define XBP_PORT_RTC_DATA 16'h0071
`define XBP_PORT_SYSCTL 16'h0061
`define XBP_SPK_GATE_BIT 1
`define XBP_IRQ8_SLOT 2'h2
`define XBP_IRQ8_BIT 0
`define XBP_DDC_SCL_BIT 1
`define XBP_DDC_SDA_BIT 0
`define XBP_DDC_IDLE 2'h3
`define XBP_RST_OE_N 1'h1
`define XBP_RST_XBUS 4'hf
`endif

// [hw/xbp_top.v]
`timescale 1ns/1ps
`include "xbp_defines.vh"
module xbp_top
(
   // Clock and reset
   input wire CLOCK_IN,
   input wire ARST_N_IN,
   // Bus strobes from the ISA clock pins
   input wire ISA_BUS_CLOCK_IN,
   input wire ISA_BUS_CLOCK_2X_IN,
   // Muxed request pins
   input wire [3:0] MUXED_ISA_IRQ_IN,
   input wire [3:0] MUXED_PCI_IRQ_IN,
   input wire [1:0] MUXED_DMA_REQ_IN,
   // Demuxed requests to the controllers
   output reg [15:0] ISA_IRQ_OUT,
   output reg [3:0] PCI_IRQ_OUT,
   output reg [7:0] DMA_REQ_OUT,
   // DMA acknowledge and count
   input wire [7:0] DMA_ACK_IN,
   input wire DMA_LAST_XFER_IN,
   output reg [2:0] ENCODED_DMA_ACK_OUT,
   output reg DMA_TERMINAL_COUNT_OUT,
   // Speaker
   input wire TIMER2_OUT_IN,
   input wire [7:0] SYSCTL_PORT_IN,
   output reg SPEAKER_OUT,
   // Internal cycle decode
   input wire CYC_MEM_IN,
   input wire CYC_IO_RD_IN,
   input wire CYC_IO_WR_IN,
   input wire [15:0] CYC_ADDR_IN,
   input wire ROM_HIT_IN,
   input wire KBD_HIT_IN,
   input wire ISA_OWNS_PINS_IN,
   input wire [3:0] IDE_DATA_HI_IN,
   // Shared X-bus pins, transceiver enable and the unshared clock-chip address strobe
   output reg ISA_XCVR_OE_N_OUT,
   output reg [3:0] XBUS_PINS_OUT,
   output reg CLOCKCHIP_ADDR_STROBE_OUT,
   // Display data channel (CRT register 3Fh bits)
   input wire [1:0] DDC_DRIVE_LOW_IN,
   output reg [1:0] DDC_SAMPLED_OUT,
   input wire [1:0] DDC_PIN_IN,
   output wire [1:0] DDC_PIN_OUT,
   output wire [1:0] DDC_PIN_OE_OUT
);
   // Two-flop synchronisers for the strobe, request and channel pins.
   reg [1:0] clk1_s_q;
   reg [1:0] clk2_s_q;
   reg [3:0] isa_s1_q;
   reg [3:0] isa_s2_q;
   reg [3:0] pci_s1_q;
   reg [3:0] pci_s2_q;
   reg [1:0] drq_s1_q;
   reg [1:0] drq_s2_q;
   reg [1:0] ddc_s1_q;
   reg [1:0] ddc_s2_q;
   // Strobe history: last synced 2x level and last synced phase.
   reg clk2_d1_q;
   reg [1:0] phase_q;
   // Combinational results of the acknowledge, cycle and line 8 decode.
   reg [2:0] ack_code;
   reg io_cycle;
   reg rtc_addr;
   reg rtc_data;
   reg sel_rom;
   reg sel_kbd;
   reg rtc_rw_n;
   reg rtc_ds_n;
   reg rtc_as;
   reg [3:0] xbus_sel_n;
   reg [3:0] xbus_d;
   reg [3:0] isa_slot;
   // Phase, settle and edge flags derived from the synced strobes.
   wire [1:0] phase;
   wire phase_settled;
   wire clk2_rise;

   // The two strobe levels name one of four phases per 1x period.
   assign phase = {clk1_s_q[1], clk2_s_q[1]};
   // A phase is trusted only once it has been seen on two clocks, so a
   // group whose pins settle a little after the strobe edge is never
   // stored into its neighbour's slot. This needs each phase to last
   // at least two clocks.
   assign phase_settled = (phase == phase_q);
   assign clk2_rise = clk2_s_q[1] & ~clk2_d1_q;

   // R17 open drain
   // The pin is only ever pulled low; the pull-up makes the high level.
   assign DDC_PIN_OUT = 2'h0;
   assign DDC_PIN_OE_OUT = DDC_DRIVE_LOW_IN;

   // Reset values match the idle pin levels, so no false edge follows.
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         clk1_s_q <= 2'h0;
         clk2_s_q <= 2'h0;
         isa_s1_q <= 4'h0;
         isa_s2_q <= 4'h0;
         pci_s1_q <= 4'h0;
         pci_s2_q <= 4'h0;
         drq_s1_q <= 2'h0;
         drq_s2_q <= 2'h0;
         ddc_s1_q <= `XBP_DDC_IDLE;
         ddc_s2_q <= `XBP_DDC_IDLE;
      end
      else
      begin
         clk1_s_q <= {clk1_s_q[0], ISA_BUS_CLOCK_IN};
         clk2_s_q <= {clk2_s_q[0], ISA_BUS_CLOCK_2X_IN};
         isa_s1_q <= MUXED_ISA_IRQ_IN;
         isa_s2_q <= isa_s1_q;
         pci_s1_q <= MUXED_PCI_IRQ_IN;
         pci_s2_q <= pci_s1_q;
         drq_s1_q <= MUXED_DMA_REQ_IN;
         drq_s2_q <= drq_s1_q;
         ddc_s1_q <= DDC_PIN_IN;
         ddc_s2_q <= ddc_s1_q;
      end
   end

   // R20 phase slots
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         clk2_d1_q <= 1'h0;
         phase_q <= 2'h0;
      end
      else
      begin
         clk2_d1_q <= clk2_s_q[1];
         phase_q <= phase;
      end
   end

   // R5 encoded ack
   // The highest active channel wins if two are ever granted together.
   always @*
   begin
      if (DMA_ACK_IN[7])
         ack_code = 3'h7;
      else if (DMA_ACK_IN[6])
         ack_code = 3'h6;
      else if (DMA_ACK_IN[5])
         ack_code = 3'h5;
      else if (DMA_ACK_IN[4])
         ack_code = 3'h4;
      else if (DMA_ACK_IN[3])
         ack_code = 3'h3;
      else if (DMA_ACK_IN[2])
         ack_code = 3'h2;
      else if (DMA_ACK_IN[1])
         ack_code = 3'h1;
      else
         ack_code = 3'h0;
   end

   // Shared terms of the cycle decode.
   always @*
   begin
      io_cycle = CYC_IO_RD_IN | CYC_IO_WR_IN;
      rtc_addr = CYC_ADDR_IN == `XBP_PORT_RTC_ADDR;
      rtc_data = CYC_ADDR_IN == `XBP_PORT_RTC_DATA;
   end

   // R8 rom select
   // R9 clock-chip select
   // An I/O cycle takes the pin over, so a stale memory hit cannot leak.
   always @*
   begin
      if (io_cycle)
         sel_rom = rtc_addr | rtc_data;
      else
         sel_rom = CYC_MEM_IN & ROM_HIT_IN;
   end

   // R11 keyboard select
   always @*
   begin
      sel_kbd = io_cycle & KBD_HIT_IN;
   end

   // R12 write strobe
   // R13 read strobe
   always @*
   begin
      rtc_rw_n = ~(CYC_IO_WR_IN & rtc_data);
      rtc_ds_n = ~(CYC_IO_RD_IN & rtc_data);
   end

   // R14 address strobe
   always @*
   begin
      rtc_as = CYC_IO_WR_IN & rtc_addr;
   end

   // Select pins in the order rom/clock, keyboard, write, data strobe.
   always @*
   begin
      xbus_sel_n = {~sel_rom, ~sel_kbd, rtc_rw_n, rtc_ds_n};
      // R10 shared pins
      if (ISA_OWNS_PINS_IN)
         xbus_d = xbus_sel_n;
      else
         xbus_d = IDE_DATA_HI_IN;
   end

   // R2 line 8 inverted
   // The clock chip drives its interrupt low, the controller wants high.
   always @*
   begin
      isa_slot = isa_s2_q;
      if (phase == `XBP_IRQ8_SLOT)
         isa_slot[`XBP_IRQ8_BIT] = ~isa_s2_q[`XBP_IRQ8_BIT];
   end

   // Each slot holds its last captured value until its phase returns.

   // R1 isa irq slot
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         ISA_IRQ_OUT <= 16'h0000;
      else if (phase_settled)
         ISA_IRQ_OUT[{phase, 2'h0} +: 4] <= isa_slot;
   end

   // R3 pci irq slot
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         PCI_IRQ_OUT <= 4'h0;
      else if (phase_settled)
         PCI_IRQ_OUT[phase] <= pci_s2_q[phase];
   end

   // R4 dma request slot
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         DMA_REQ_OUT <= 8'h00;
      else if (phase_settled)
         DMA_REQ_OUT[{phase, 1'h0} +: 2] <= drq_s2_q;
   end

   // R5 encoded ack
   // The code changes only at a 2x rise, so the decoder sees it steady.
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         ENCODED_DMA_ACK_OUT <= 3'h0;
      else if (clk2_rise)
         ENCODED_DMA_ACK_OUT <= ack_code;
   end

   // R6 terminal count
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         DMA_TERMINAL_COUNT_OUT <= 1'h0;
      else
         DMA_TERMINAL_COUNT_OUT <= DMA_LAST_XFER_IN;
   end

   // R7 speaker gate
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         SPEAKER_OUT <= 1'h0;
      else
         SPEAKER_OUT <= TIMER2_OUT_IN & SYSCTL_PORT_IN[`XBP_SPK_GATE_BIT];
   end

   // R19 transceiver enable
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         ISA_XCVR_OE_N_OUT <= `XBP_RST_OE_N;
      else
         ISA_XCVR_OE_N_OUT <= ~ISA_OWNS_PINS_IN;
   end

   // Reset leaves every shared select inactive, that is high.
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         XBUS_PINS_OUT <= `XBP_RST_XBUS;
      else
         XBUS_PINS_OUT <= xbus_d;
   end

   // The address strobe has a pin of its own and is never shared.
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         CLOCKCHIP_ADDR_STROBE_OUT <= 1'h0;
      else
         CLOCKCHIP_ADDR_STROBE_OUT <= rtc_as;
   end

   // R18 clock and data
   always @(posedge CLOCK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
         DDC_SAMPLED_OUT <= `XBP_DDC_IDLE;
      else
         DDC_SAMPLED_OUT <= {ddc_s2_q[`XBP_DDC_SCL_BIT],
            ddc_s2_q[`XBP_DDC_SDA_BIT]};
   end
endmodule

// [sim/xbp_link_model.sv]
`timescale 1ns/1ps
module xbp_link_model
(
   // Request levels to encode, a group for every strobe phase
   input wire [27:0] REQ_IN,
   // Strobes and muxed pins
   output logic CLK_OUT = 0,
   output logic CLK2X_OUT = 0,
   output wire [9:0] PINS_OUT
);
   wire [1:0] ph = {CLK_OUT, CLK2X_OUT};
   always #200 CLK2X_OUT = ~CLK2X_OUT;
   always @(negedge CLK2X_OUT) CLK_OUT <= ~CLK_OUT;
   // each phase puts its own ISA and DMA groups on the pins; all four PCI levels stay on
   assign PINS_OUT = {REQ_IN[20 + 2 * ph +: 2], REQ_IN[19:16],
      REQ_IN[4 * ph +: 4]};
endmodule

// [sim/xbp_top_bench.sv]
`timescale 1ns/1ps
module xbp_top_bench;
   logic CLOCK_IN = 0, ARST_N_IN = 0, TIMER2_OUT_IN = 0, CYC_MEM_IN = 0;
   logic DMA_LAST_XFER_IN = 0, CYC_IO_RD_IN = 0, CYC_IO_WR_IN = 0;
   logic ROM_HIT_IN = 0, KBD_HIT_IN = 0, ISA_OWNS_PINS_IN = 0;
   logic [7:0] SYSCTL_PORT_IN = '0, DMA_ACK_IN = '0;
   logic [15:0] CYC_ADDR_IN = '0;
   logic [3:0] IDE_DATA_HI_IN = '0;
   logic [1:0] DDC_DRIVE_LOW_IN = '0;
   logic [27:0] req = '0;
   wire ISA_BUS_CLOCK_IN, ISA_BUS_CLOCK_2X_IN, DMA_TERMINAL_COUNT_OUT;
   wire SPEAKER_OUT, ISA_XCVR_OE_N_OUT, CLOCKCHIP_ADDR_STROBE_OUT;
   wire [3:0] MUXED_ISA_IRQ_IN, MUXED_PCI_IRQ_IN, PCI_IRQ_OUT, XBUS_PINS_OUT;
   wire [1:0] MUXED_DMA_REQ_IN, DDC_SAMPLED_OUT, DDC_PIN_OUT, DDC_PIN_OE_OUT;
   wire [15:0] ISA_IRQ_OUT;
   wire [7:0] DMA_REQ_OUT;
   wire [2:0] ENCODED_DMA_ACK_OUT;
   // Pulled-up open-drain pins: only the block pulls them low.
   wire [1:0] DDC_PIN_IN = ~DDC_PIN_OE_OUT;
   int n_fail = 0, n_compared = 0;
   xbp_top dut (.*);
   xbp_link_model link (.REQ_IN(req), .CLK_OUT(ISA_BUS_CLOCK_IN),
      .CLK2X_OUT(ISA_BUS_CLOCK_2X_IN),
      .PINS_OUT({MUXED_DMA_REQ_IN, MUXED_PCI_IRQ_IN, MUXED_ISA_IRQ_IN}));
   task cyc(int n);
      repeat (n) @(negedge CLOCK_IN);
   endtask
   task chk(logic [15:0] g, logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("%0d compared, %0d failed", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task step(logic [4:0] c, logic [15:0] a, logic [3:0] e);
      {CYC_MEM_IN, ROM_HIT_IN, KBD_HIT_IN, CYC_IO_RD_IN, CYC_IO_WR_IN} = c;
      CYC_ADDR_IN = a;
      cyc(2);
      chk(XBUS_PINS_OUT, e);
      chk(CLOCKCHIP_ADDR_STROBE_OUT, c[0] && a == 16'h0070);
   endtask
   task t_core;
      for (int i = 0; i < 4; i++)
      begin
         {TIMER2_OUT_IN, SYSCTL_PORT_IN[1], DMA_LAST_XFER_IN} = {i[1:0], i[0]};
         cyc(2);
         chk(SPEAKER_OUT, i == 3);
         chk(DMA_TERMINAL_COUNT_OUT, i[0]);
      end
      ISA_OWNS_PINS_IN = 1;
      step(5'h18, 16'h0000, 4'h7);
      step(5'h01, 16'h0070, 4'h7);
      step(5'h01, 16'h0071, 4'h5);
      step(5'h02, 16'h0071, 4'h6);
      step(5'h06, 16'h0060, 4'hB);
      chk(ISA_XCVR_OE_N_OUT, 1'h0);
      {ISA_OWNS_PINS_IN, IDE_DATA_HI_IN} = 5'h0A;
      step(5'h01, 16'h0071, 4'hA);
      chk(XBUS_PINS_OUT | {4{ISA_XCVR_OE_N_OUT}}, 4'hF);
      $display("core test done");
   endtask
   task t_link;
      {req, DMA_ACK_IN, DDC_DRIVE_LOW_IN} = {28'hFFF_FFFF, 8'h20, 2'h1};
      cyc(40);
      chk(ISA_IRQ_OUT, 16'hFEFF);
      chk({PCI_IRQ_OUT, DMA_REQ_OUT}, 12'hFFF);
      chk({ENCODED_DMA_ACK_OUT, DDC_PIN_OE_OUT, DDC_SAMPLED_OUT}, 7'h56);
      {req, DMA_ACK_IN, DDC_DRIVE_LOW_IN} = {28'hC65_1234, 8'h81, 2'h2};
      cyc(40);
      chk(ISA_IRQ_OUT, 16'h1334);
      chk({PCI_IRQ_OUT, DMA_REQ_OUT}, 12'h5C6);
      chk(DDC_PIN_OUT, 2'h0);
      chk({ENCODED_DMA_ACK_OUT, DDC_PIN_OE_OUT, DDC_SAMPLED_OUT}, 7'h79);
      $display("link test done");
   endtask
   initial
   forever
      #50 CLOCK_IN = ~CLOCK_IN;
   initial
   begin
      cyc(12);
      ARST_N_IN = 1;
      cyc(2);
      t_core;
      t_link;
      conclude;
   end
endmodule

// [sim/xbp_top_sva.sv]
`timescale 1ns/1ps
module xbp_top_sva
(
   // Clock, reset and causes
   input wire CLOCK_IN,
   input wire ARST_N_IN,
   input wire TIMER2_OUT_IN,
   input wire [7:0] SYSCTL_PORT_IN,
   input wire DMA_LAST_XFER_IN,
   input wire CYC_IO_RD_IN,
   input wire CYC_IO_WR_IN,
   input wire [15:0] CYC_ADDR_IN,
   input wire KBD_HIT_IN,
   input wire ISA_OWNS_PINS_IN,
   input wire [3:0] IDE_DATA_HI_IN,
   // Effects
   input wire SPEAKER_OUT,
   input wire DMA_TERMINAL_COUNT_OUT,
   input wire ISA_XCVR_OE_N_OUT,
   input wire [3:0] XBUS_PINS_OUT,
   input wire CLOCKCHIP_ADDR_STROBE_OUT
);
   logic up_q;
   wire own = ISA_OWNS_PINS_IN;
   wire p71 = CYC_ADDR_IN == 16'h0071;
   wire w70 = CYC_IO_WR_IN && CYC_ADDR_IN == 16'h0070;
   // Keeps $past from judging inputs taken while still in reset.
   always @(posedge CLOCK_IN or negedge ARST_N_IN) up_q <= ARST_N_IN;
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   a_spk_gate: assert property (up_q |-> SPEAKER_OUT ==
      $past(TIMER2_OUT_IN & SYSCTL_PORT_IN[1])) else $error("spk");
   a_tc_last: assert property (up_q |-> DMA_TERMINAL_COUNT_OUT ==
      $past(DMA_LAST_XFER_IN)) else $error("tc");
   a_oe_follow: assert property (up_q |-> ISA_XCVR_OE_N_OUT !=
      $past(own)) else $error("oe");
   a_ide_pass: assert property (up_q && !$past(own) |->
      XBUS_PINS_OUT == $past(IDE_DATA_HI_IN)) else $error("ide");
   a_addr_strobe: assert property (up_q |->
      CLOCKCHIP_ADDR_STROBE_OUT == $past(w70)) else $error("as");
   a_rw_write: assert property (up_q && $past(own && CYC_IO_WR_IN && p71)
      |-> !XBUS_PINS_OUT[1]) else $error("rw");
   a_ds_read: assert property (up_q && $past(own && CYC_IO_RD_IN && p71)
      |-> !XBUS_PINS_OUT[0]) else $error("ds");
   a_kbd_select: assert property (up_q && $past(own && KBD_HIT_IN &&
      (CYC_IO_RD_IN || CYC_IO_WR_IN)) |-> !XBUS_PINS_OUT[2]) else $error("kb");
endmodule
bind xbp_top xbp_top_sva chk (.*);
